//--- inc/swpc_pkg.sv
// Package for the sleep and wake power controller: states, sources, timing
package swpc_pkg;

	// System power states, Gray coded along S0 -> S3 -> S4 -> S5
	typedef enum logic [1:0] {
		SWPC_S0 = 2'h0,
		SWPC_S3 = 2'h1,
		SWPC_S4 = 2'h3,
		SWPC_S5 = 2'h2
	} swpc_state_t;

	// Sleep commands from the platform controller
	typedef enum logic [1:0] {
		SWPC_CMD_NONE = 2'h0,
		SWPC_CMD_S3   = 2'h1,
		SWPC_CMD_S4   = 2'h2,
		SWPC_CMD_S5   = 2'h3
	} swpc_cmd_t;

	// Wake source bit positions
	localparam int SWPC_SRC_PWRSW  = 0;
	localparam int SWPC_SRC_RTC    = 1;
	localparam int SWPC_SRC_LAN    = 2;
	localparam int SWPC_SRC_USB    = 3;
	localparam int SWPC_SRC_PCIPME = 4;
	localparam int SWPC_SRC_PCIEWK = 5;
	localparam int SWPC_SRC_SERIAL = 6;
	localparam int SWPC_NSRC       = 7;

	// Sources allowed per sleep state
	localparam logic [6:0] SWPC_WAKE_MASK_S3  = 7'h7f;
	localparam logic [6:0] SWPC_WAKE_MASK_S45 = 7'h37;
	localparam logic [6:0] SWPC_ZERO_SRC      = 7'h00;

	// Sleep indicator behaviour selections
	localparam logic [1:0] SWPC_LED_OFF   = 2'h0;
	localparam logic [1:0] SWPC_LED_BLINK = 2'h1;
	localparam logic [1:0] SWPC_LED_ON    = 2'h2;

	// Fan PWM: 25 kHz from 100 MHz, 8-bit duty
	localparam int          SWPC_CLK_HZ      = 100_000_000;
	localparam int          SWPC_PWM_HZ      = 25_000;
	localparam int          SWPC_PWM_PERIOD  = SWPC_CLK_HZ / SWPC_PWM_HZ;
	localparam int          SWPC_PWM_CW      = 12;
	localparam logic [11:0] SWPC_PWM_TOP     =
		12'(SWPC_PWM_PERIOD - 1);
	localparam logic [11:0] SWPC_PWM_ZERO    = 12'h000;
	localparam int          SWPC_DUTY_SHIFT  = 4;

	// Sleep LED blink half period, 500 ms
	localparam int          SWPC_BLINK_MS    = 500;
	localparam int          SWPC_BLINK_CYC   =
		SWPC_CLK_HZ / 1000 * SWPC_BLINK_MS;
	localparam int          SWPC_BLINK_CW    = 26;
	localparam logic [25:0] SWPC_BLINK_ZERO  = 26'h0000000;

	// Restore-policy encodings
	localparam logic [1:0] SWPC_AC_STAY_OFF = 2'h0;
	localparam logic [1:0] SWPC_AC_LAST     = 2'h1;
	localparam logic [1:0] SWPC_AC_POWER_ON = 2'h2;

endpackage : swpc_pkg

//--- rtl/swpc_fan_pwm.sv
// One fan output channel: PWM for 4-pin fans, linear level for 3-wire fans
`timescale 1ns/1ns
`default_nettype none
module swpc_fan_pwm (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       ce,
	input  wire logic       run,
	input  wire logic [7:0] duty,
	input  wire logic [11:0] phase,
	output var  logic       pwmOut,
	output var  logic [7:0] linearLevel
);
	import swpc_pkg::*;

	logic       pwm_next;
	logic [7:0] lin_next;
	logic [11:0] thresh;

	always_comb begin
		thresh   = {duty, 4'h0};
		pwm_next = run && (phase < thresh);
		lin_next = run ? duty : 8'h00;
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			pwmOut      <= 1'b0;
			linearLevel <= 8'h00;
		end else if (ce) begin
			pwmOut      <= pwm_next;
			linearLevel <= lin_next;
		end
	end
endmodule : swpc_fan_pwm
`default_nettype wire

//--- rtl/swpc_power_ctrl.sv
// Sleep and wake power controller: state, wake gating, rails, fans, LED
// What this block does
// - A conventional PCI power event wakes the system from S3, S4 or S5.
// - A PCI Express wake line wakes the system from S3, S4 or S5.
// - USB activity wakes the system from S3 only, never from S4 or S5.
// - Serial port activity wakes the system from S3 only.
// - USB port power is removed in S4 and S5.
// - All fans run while the system is in S0.
// - All fans stop in S3, S4 and S5.
// - Four-pin fans get a pulse-width-modulated speed output.
// - Three-wire front and rear fans also get a linear supply level.
// - After AC loss the prior on or off state is restored if so set.
// - A soft-off command tells the supply to drop all but standby.
// - In S3 an enabled wake returns to the working state, memory kept.
// - In S3 the main supply is off and the power LED follows a setting.
`timescale 1ns/1ns
`default_nettype none
module swpc_power_ctrl (
	input  wire logic               clk,
	input  wire logic               resetn,
	input  wire logic               ce,
	input  wire swpc_pkg::swpc_cmd_t sleepCmd,
	input  wire logic               powerSwitch,
	input  wire logic               rtcAlarm,
	input  wire logic               lanWake,
	input  wire logic               usbActivity,
	input  wire logic               pciPme,
	input  wire logic               pcieWake,
	input  wire logic               serialActivity,
	input  wire logic [6:0]         wakeEnable,
	input  wire logic [6:0]         wakeStatusClear,
	input  wire logic [1:0]         acRestorePolicy,
	input  wire logic [1:0]         sleep_led_behaviour_select,
	input  wire logic [7:0]         fanDuty,
	input  wire logic               lastStateValid,
	input  wire logic               lastStateOn,
	output var  swpc_pkg::swpc_state_t sysState,
	output var  logic               mainSupplyOn,
	output var  logic               memSelfRefresh,
	output var  logic               usbPortPowerEn,
	output var  logic               cpuFanPwm,
	output var  logic               frontFanPwm,
	output var  logic               rearFanPwm,
	output var  logic [7:0]         frontFanLinear,
	output var  logic [7:0]         rearFanLinear,
	output var  logic               powerLed,
	output var  logic [6:0]         wakeStatus,
	output var  logic               wakeEvent,
	output var  logic               lastStateOnOut
);
	import swpc_pkg::*;

	// State group
	swpc_state_t state_reg, state_next;
	logic        boot_reg, boot_next;
	logic        supply_reg, supply_next;
	logic        selfRef_reg, selfRef_next;
	logic        usbPwr_reg, usbPwr_next;
	logic        wakeEv_reg, wakeEv_next;
	logic        onMem_reg, onMem_next;

	// Wake flag group
	logic [6:0]  flags_reg, flags_next;

	// LED and PWM timer group
	logic [11:0] phase_reg, phase_next;
	logic [25:0] blink_reg, blink_next;
	logic        blinkPh_reg, blinkPh_next;
	logic        led_reg, led_next;

	logic [6:0]  srcRaw;
	logic [6:0]  allowed;
	logic [6:0]  wakeHits;
	logic        fanRun;

	// Powerswitch is level sensitive here; platform debounce is upstream
	always_comb begin
		srcRaw = SWPC_ZERO_SRC;
		srcRaw[SWPC_SRC_PWRSW]  = powerSwitch;
		srcRaw[SWPC_SRC_RTC]    = rtcAlarm;
		srcRaw[SWPC_SRC_LAN]    = lanWake;
		srcRaw[SWPC_SRC_USB]    = usbActivity;
		srcRaw[SWPC_SRC_PCIPME] = pciPme;
		srcRaw[SWPC_SRC_PCIEWK] = pcieWake;
		srcRaw[SWPC_SRC_SERIAL] = serialActivity;
	end

	// Per-state gating of wake sources
	always_comb begin
		unique case (state_reg)
			SWPC_S3: allowed = SWPC_WAKE_MASK_S3;
			SWPC_S4,
			SWPC_S5: allowed = SWPC_WAKE_MASK_S45;
			SWPC_S0: allowed = SWPC_ZERO_SRC;
		endcase
		// The restore decision owns the boot cycle; no wake is taken then
		wakeHits = boot_reg ? SWPC_ZERO_SRC :
			srcRaw & allowed & wakeEnable;
	end

	// Power state machine
	always_comb begin
		state_next   = state_reg;
		boot_next    = 1'b0;
		onMem_next   = onMem_reg;
		wakeEv_next  = 1'b0;
		if (boot_reg) begin
			// AC restore decision taken once after reset release
			unique case (acRestorePolicy)
				SWPC_AC_LAST:
					state_next = (lastStateValid && lastStateOn) ?
						SWPC_S0 : SWPC_S5;
				SWPC_AC_POWER_ON: state_next = SWPC_S0;
				default:          state_next = SWPC_S5;
			endcase
		end else if (state_reg == SWPC_S0) begin
			unique case (sleepCmd)
				SWPC_CMD_S3: state_next = SWPC_S3;
				SWPC_CMD_S4: state_next = SWPC_S4;
				SWPC_CMD_S5: state_next = SWPC_S5;
				SWPC_CMD_NONE: state_next = SWPC_S0;
			endcase
		end else if (|wakeHits) begin
			state_next  = SWPC_S0;
			wakeEv_next = 1'b1;
		end
		if (!boot_reg) begin
			onMem_next = (state_next != SWPC_S5);
		end
	end

	// Outputs derived from the next state, so they land with it
	always_comb begin
		supply_next  = (state_next == SWPC_S0);
		selfRef_next = (state_next == SWPC_S3);
		usbPwr_next  = (state_next == SWPC_S0) ||
			(state_next == SWPC_S3);
	end

	// Sticky wake flags: a new event beats a clear in the same cycle
	always_comb begin
		flags_next = (flags_reg & ~wakeStatusClear) |
			wakeHits;
	end

	// PWM phase and sleep LED blink
	always_comb begin
		phase_next   = (phase_reg == SWPC_PWM_TOP) ?
			SWPC_PWM_ZERO : phase_reg + 12'h001;
		blinkPh_next = blinkPh_reg;
		if (blink_reg == 26'(SWPC_BLINK_CYC - 1)) begin
			blink_next   = SWPC_BLINK_ZERO;
			blinkPh_next = ~blinkPh_reg;
		end else begin
			blink_next = blink_reg + 26'h0000001;
		end
		unique case (state_next)
			SWPC_S0: led_next = 1'b1;
			SWPC_S3: begin
				unique case (sleep_led_behaviour_select)
					SWPC_LED_BLINK: led_next = blinkPh_reg;
					SWPC_LED_ON:    led_next = 1'b1;
					default:        led_next = 1'b0;
				endcase
			end
			SWPC_S4, SWPC_S5: led_next = 1'b0;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state_reg   <= SWPC_S5;
			boot_reg    <= 1'b1;
			supply_reg  <= 1'b0;
			selfRef_reg <= 1'b0;
			usbPwr_reg  <= 1'b0;
			wakeEv_reg  <= 1'b0;
			onMem_reg   <= 1'b0;
		end else if (ce) begin
			state_reg   <= state_next;
			boot_reg    <= boot_next;
			supply_reg  <= supply_next;
			selfRef_reg <= selfRef_next;
			usbPwr_reg  <= usbPwr_next;
			wakeEv_reg  <= wakeEv_next;
			onMem_reg   <= onMem_next;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flags_reg <= SWPC_ZERO_SRC;
		end else if (ce) begin
			flags_reg <= flags_next;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			phase_reg   <= SWPC_PWM_ZERO;
			blink_reg   <= SWPC_BLINK_ZERO;
			blinkPh_reg <= 1'b0;
			led_reg     <= 1'b0;
		end else if (ce) begin
			phase_reg   <= phase_next;
			blink_reg   <= blink_next;
			blinkPh_reg <= blinkPh_next;
			led_reg     <= led_next;
		end
	end

	// Fans run only in S0; the supply is the main rail anyway
	assign fanRun = (state_reg == SWPC_S0);

	swpc_fan_pwm uCpuFan (
		.clk        (clk),
		.resetn     (resetn),
		.ce         (ce),
		.run        (fanRun),
		.duty       (fanDuty),
		.phase      (phase_reg),
		.pwmOut     (cpuFanPwm),
		.linearLevel()
	);

	swpc_fan_pwm uFrontFan (
		.clk        (clk),
		.resetn     (resetn),
		.ce         (ce),
		.run        (fanRun),
		.duty       (fanDuty),
		.phase      (phase_reg),
		.pwmOut     (frontFanPwm),
		.linearLevel(frontFanLinear)
	);

	swpc_fan_pwm uRearFan (
		.clk        (clk),
		.resetn     (resetn),
		.ce         (ce),
		.run        (fanRun),
		.duty       (fanDuty),
		.phase      (phase_reg),
		.pwmOut     (rearFanPwm),
		.linearLevel(rearFanLinear)
	);

	assign sysState       = state_reg;
	assign mainSupplyOn   = supply_reg;
	assign memSelfRefresh = selfRef_reg;
	assign usbPortPowerEn = usbPwr_reg;
	assign powerLed       = led_reg;
	assign wakeStatus     = flags_reg;
	assign wakeEvent      = wakeEv_reg;
	assign lastStateOnOut = onMem_reg;
endmodule : swpc_power_ctrl
`default_nettype wire

//--- tb/swpc_wake_model.sv
// Far side model: wake sources and supply rails
`timescale 1ns/1ns
`default_nettype none
module swpc_wake_model (
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic [6:0] trig,
	input  wire logic       mainSupplyOn,
	output var  logic [6:0] wk,
	output var  logic       railsOn
);
	logic [6:0] wake_reg;
	logic [6:0] wake_next;
	logic       rails_reg;
	always_comb begin
		wake_next = trig;
	end
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			wake_reg <= 7'h00;
			rails_reg <= 1'b0;
		end else begin
			wake_reg <= wake_next;
			rails_reg <= mainSupplyOn;
		end
	end
	assign wk = wake_reg;
	assign railsOn = rails_reg;
endmodule : swpc_wake_model
`default_nettype wire

//--- tb/swpc_power_ctrl_properties.sv
// Checker for the sleep and wake power controller ports
`timescale 1ns/1ns
`default_nettype none
module swpc_power_ctrl_chk (
	input wire logic                  clk,
	input wire logic                  resetn,
	input wire logic                  ce,
	input wire swpc_pkg::swpc_cmd_t   sleepCmd,
	input wire logic                  powerSwitch,
	input wire logic                  rtcAlarm,
	input wire logic                  lanWake,
	input wire logic                  pciPme,
	input wire logic                  pcieWake,
	input wire logic                  serialActivity,
	input wire logic [6:0]            wakeEnable,
	input wire logic [6:0]            wakeStatusClear,
	input wire logic [7:0]            fanDuty,
	input wire swpc_pkg::swpc_state_t sysState,
	input wire logic                  mainSupplyOn,
	input wire logic                  memSelfRefresh,
	input wire logic                  usbPortPowerEn,
	input wire logic                  cpuFanPwm,
	input wire logic [7:0]            frontFanLinear,
	input wire logic [6:0]            wakeStatus,
	input wire logic                  wakeEvent
);
	import swpc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);
	a_pci_wake: assert property (
		sysState != SWPC_S0 && ce && pciPme &&
		wakeEnable[SWPC_SRC_PCIPME] |=> sysState == SWPC_S0 &&
		wakeStatus[SWPC_SRC_PCIPME]) else $error("pci wake lost");
	a_pcie_wake: assert property (
		sysState != SWPC_S0 && ce && pcieWake &&
		wakeEnable[SWPC_SRC_PCIEWK] |=> sysState == SWPC_S0 &&
		wakeStatus[SWPC_SRC_PCIEWK]) else $error("pcie wake lost");
	a_usb_s3_only: assert property (
		$rose(wakeStatus[SWPC_SRC_USB]) |-> $past(sysState) == SWPC_S3)
		else $error("usb wake outside S3");
	a_serial_wake: assert property (
		sysState == SWPC_S3 && ce && serialActivity &&
		wakeEnable[SWPC_SRC_SERIAL] |=> sysState == SWPC_S0)
		else $error("serial wake lost");
	a_usb_power_off: assert property (
		sysState inside {SWPC_S4, SWPC_S5} |-> !usbPortPowerEn)
		else $error("usb power in deep sleep");
	a_fans_run: assert property (
		$past(resetn, 2) && $past(sysState) == SWPC_S0 && $past(ce)
		|-> frontFanLinear == $past(fanDuty))
		else $error("fan not running");
	// Fan flops only move on an enabled edge, so the first cycle needs ce
	a_fans_stop: assert property (
		sysState != SWPC_S0 && ce ##1 sysState != SWPC_S0
		|-> !cpuFanPwm && frontFanLinear == 8'h00)
		else $error("fan running in sleep");
	a_soft_off: assert property (
		sysState == SWPC_S0 && ce && sleepCmd != SWPC_CMD_NONE
		|=> !mainSupplyOn) else $error("supply kept on");
	a_s3_context: assert property (
		sysState == SWPC_S3 |-> !mainSupplyOn && memSelfRefresh)
		else $error("S3 supply or memory wrong");
	a_core_wake: assert property (
		sysState != SWPC_S0 && ce && |(wakeEnable[2:0] &
		{lanWake, rtcAlarm, powerSwitch}) |=> sysState == SWPC_S0)
		else $error("core wake lost");
	a_flag_hold: assert property (
		ce && wakeStatus[0] && !wakeStatusClear[0] |=> wakeStatus[0])
		else $error("wake flag lost");
	a_event_pulse: assert property (
		wakeEvent && ce |=> !wakeEvent) else $error("wake pulse long");
	c_s3_wake: cover property (sysState == SWPC_S3 ##1 sysState == SWPC_S0);
	c_s5_wake: cover property (sysState == SWPC_S5 ##1 wakeEvent);
	c_pwm: cover property ($rose(cpuFanPwm));
endmodule : swpc_power_ctrl_chk
bind swpc_power_ctrl swpc_power_ctrl_chk i_chk (.*);
`default_nettype wire

//--- tb/swpc_power_ctrl_tb.sv
// Self-checking bench for the sleep and wake power controller
`timescale 1ns/1ns
`default_nettype none
module swpc_power_ctrl_tb;
	import swpc_pkg::*;
	localparam int TMO = 20000;
	logic        clk, resetn, ce, lastStateValid, lastStateOn, railsOn;
	swpc_cmd_t   sleepCmd;
	swpc_state_t sysState;
	logic [6:0]  wakeEnable, wakeStatusClear, wakeStatus, trig, wk;
	logic [1:0]  acRestorePolicy, sleep_led_behaviour_select;
	logic [7:0]  fanDuty, frontFanLinear, rearFanLinear;
	logic        mainSupplyOn, memSelfRefresh, usbPortPowerEn, powerLed;
	logic        cpuFanPwm, frontFanPwm, rearFanPwm, wakeEvent, lastStateOnOut;
	wire logic   powerSwitch, rtcAlarm, lanWake, usbActivity;
	wire logic   pciPme, pcieWake, serialActivity;
	int          mismatches, checksDone, cycles;
	assign {serialActivity, pcieWake, pciPme, usbActivity} = wk[6:3];
	assign {lanWake, rtcAlarm, powerSwitch} = wk[2:0];
	swpc_power_ctrl i_dut (.*);
	swpc_wake_model i_far (.clk(clk), .resetn(resetn), .trig(trig),
		.mainSupplyOn(mainSupplyOn), .wk(wk), .railsOn(railsOn));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic testDone();
		$display("checks %0d mismatches %0d", checksDone, mismatches);
		if (mismatches == 0 && checksDone > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : testDone
	always @(posedge clk) begin
		cycles++;
		if (cycles == TMO) begin
			mismatches++;
			testDone();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
			mismatches++;
		end
	endtask : chk
	function automatic swpc_state_t stOf(input int c);
		return c == 1 ? SWPC_S3 : (c == 2 ? SWPC_S4 : SWPC_S5);
	endfunction : stOf
	// Far side raises the lines one edge after trig, DUT takes the next
	task automatic fire(input logic [6:0] b);
		@(posedge clk) trig <= b;
		@(posedge clk) trig <= 7'h00;
		repeat (2) @(posedge clk);
		@(negedge clk);
	endtask : fire
	task automatic clr();
		@(posedge clk) wakeStatusClear <= 7'h7f;
		@(posedge clk) wakeStatusClear <= 7'h00;
		@(negedge clk);
		chk(wakeStatus, 16'h0000);
	endtask : clr
	task automatic rst(input int i);
		logic up;
		up = i % 4 == 2 || (i % 4 == 1 && i[2] && i[0]);
		@(posedge clk) resetn <= 1'b0;
		acRestorePolicy <= 2'(i);
		lastStateValid <= i[2];
		lastStateOn <= i[0];
		repeat (3) @(posedge clk);
		resetn <= 1'b1;
		repeat (2) @(posedge clk);
		@(negedge clk);
		chk(sysState, up ? SWPC_S0 : SWPC_S5);
		chk(lastStateOnOut, up);
	endtask : rst
	initial begin
		logic [6:0] en;
		logic [1:0] sel;
		logic [7:0] duty;
		logic       w;
		int         hi;
		resetn = 1'b0;
		ce = 1'b1;
		sleepCmd = SWPC_CMD_NONE;
		trig = 7'h00;
		wakeEnable = 7'h00;
		wakeStatusClear = 7'h00;
		acRestorePolicy = 2'h0;
		sleep_led_behaviour_select = 2'h0;
		fanDuty = 8'h00;
		lastStateValid = 1'b0;
		lastStateOn = 1'b0;
		void'($urandom(32'hbb0f));
		for (int i = 0; i < 8; i++) rst(i);
		@(posedge clk) wakeEnable <= 7'h7f;
		fire(7'h01);
		clr();
		for (int s = 0; s < 7; s++) begin
			for (int c = 1; c < 4; c++) begin
				en = 7'($urandom);
				// S3 must take it, S5 must refuse usb and serial
				if (c != 2) en[s] = 1'b1;
				sel = 2'($urandom);
				duty = 8'($urandom);
				@(posedge clk) wakeEnable <= en;
				sleep_led_behaviour_select <= sel;
				fanDuty <= duty;
				sleepCmd <= swpc_cmd_t'(c);
				@(posedge clk) sleepCmd <= SWPC_CMD_NONE;
				repeat (3) @(negedge clk);
				chk(sysState, stOf(c));
				chk(lastStateOnOut, c != 3);
				chk({mainSupplyOn, railsOn}, 16'h0000);
				chk(usbPortPowerEn, c == 1);
				chk({cpuFanPwm, frontFanPwm, rearFanPwm}, 16'h0000);
				chk(frontFanLinear | rearFanLinear, 16'h0000);
				if (!(c == 1 && sel == 1)) chk(powerLed, c == 1 && sel == 2);
				fire(7'(1 << s));
				w = en[s] && (c == 1 || (s != 3 && s != 6));
				chk(sysState, w ? SWPC_S0 : stOf(c));
				chk(wakeStatus, w ? 7'(1 << s) : 7'h00);
				if (!w) begin
					@(posedge clk) wakeEnable <= 7'h7f;
					fire(7'h01);
				end
				clr();
				chk({frontFanLinear, rearFanLinear}, {duty, duty});
			end
		end
		// A low clock enable must hold off a pending sleep command
		@(posedge clk) ce <= 1'b0;
		sleepCmd <= SWPC_CMD_S3;
		wakeEnable <= 7'h7f;
		repeat (3) @(posedge clk);
		@(negedge clk);
		chk(sysState, SWPC_S0);
		chk(mainSupplyOn, 1'b1);
		@(posedge clk) ce <= 1'b1;
		@(posedge clk) sleepCmd <= SWPC_CMD_NONE;
		@(negedge clk);
		chk(sysState, SWPC_S3);
		fire(7'h01);
		chk(sysState, SWPC_S0);
		chk(wakeStatus, 16'h0001);
		clr();
		duty = 8'($urandom);
		@(posedge clk) fanDuty <= duty;
		repeat (4100) @(posedge clk);
		hi = 0;
		repeat (4000) begin
			@(negedge clk);
			hi += int'(cpuFanPwm === 1'b1);
		end
		chk(16'(hi), duty * 16 > 4000 ? 16'd4000 : 16'(duty * 16));
		testDone();
	end
endmodule : swpc_power_ctrl_tb
`default_nettype wire
